/* File: msr_pkg.sv */
// constants, types and the special-register number classifier
`timescale 1ns/1ps
`default_nettype none

package msr_pkg;
   // widths
   localparam int unsigned MSR_GPR_W     = 32;
   localparam int unsigned MSR_SPR_W     = 10;
   localparam int unsigned MSR_HALF_W    = 5;
   localparam int unsigned MSR_SEG_W     = 4;
   localparam int unsigned MSR_GIDX_W    = 5;

   // instruction field positions, lsb-0 numbering of a 32-bit word
   localparam int unsigned MSR_F_PRIM_LSB = 26;
   localparam int unsigned MSR_F_TGT_LSB  = 21;
   localparam int unsigned MSR_F_A_LSB    = 16;
   localparam int unsigned MSR_F_B_LSB    = 11;
   localparam int unsigned MSR_F_XO_LSB   = 1;
   localparam int unsigned MSR_F_REC_BIT  = 0;
   localparam int unsigned MSR_F_SEG_LSB  = 17;
   localparam int unsigned MSR_F_SEG_MSB  = 19;
   localparam int unsigned MSR_G_SEG_LSB  = 28;

   // opcodes
   localparam logic [5:0] MSR_OP_PRIMARY = 6'h1f;
   localparam logic [9:0] MSR_XO_MFSPR   = 10'h153;
   localparam logic [9:0] MSR_XO_MFSR    = 10'h253;
   localparam logic [9:0] MSR_XO_MFSRI   = 10'h273;
   localparam logic [9:0] MSR_XO_MFSRIN  = 10'h293;

   // special register numbers, after the half swap
   localparam logic [9:0] MSR_N_FIXED_EXC    = 10'h001;
   localparam logic [9:0] MSR_N_LINK         = 10'h008;
   localparam logic [9:0] MSR_N_COUNT        = 10'h009;
   localparam logic [9:0] MSR_N_FAULT_CAUSE  = 10'h012;
   localparam logic [9:0] MSR_N_FAULT_ADDR   = 10'h013;
   localparam logic [9:0] MSR_N_DEC_NEW      = 10'h016;
   localparam logic [9:0] MSR_N_PAGE_BASE    = 10'h019;
   localparam logic [9:0] MSR_N_SAVE_PC      = 10'h01a;
   localparam logic [9:0] MSR_N_SAVE_STATE   = 10'h01b;
   localparam logic [9:0] MSR_N_SCRATCH_LO   = 10'h110;
   localparam logic [9:0] MSR_N_SCRATCH_HI   = 10'h113;
   localparam logic [9:0] MSR_N_EXT_ACCESS   = 10'h11a;
   localparam logic [9:0] MSR_N_TB_LOWER     = 10'h11c;
   localparam logic [9:0] MSR_N_TB_UPPER     = 10'h11d;
   localparam logic [9:0] MSR_N_WINDOW_LO    = 10'h210;
   localparam logic [9:0] MSR_N_WINDOW_HI    = 10'h21f;
   localparam logic [9:0] MSR_N_MUL_QUOT     = 10'h000;
   localparam logic [9:0] MSR_N_RTC_UPPER    = 10'h004;
   localparam logic [9:0] MSR_N_RTC_LOWER    = 10'h005;
   localparam logic [9:0] MSR_N_DEC_OLD      = 10'h006;

   // exception causes
   localparam logic [1:0] MSR_EXC_NONE    = 2'h0;
   localparam logic [1:0] MSR_EXC_PRIV    = 2'h1;
   localparam logic [1:0] MSR_EXC_INVALID = 2'h2;

   // reset values
   localparam logic [31:0] MSR_RST_DATA = 32'h0000_0000;
   localparam logic [9:0]  MSR_RST_NUM  = 10'h000;
   localparam logic [4:0]  MSR_RST_GIDX = 5'h00;
   localparam logic [3:0]  MSR_RST_SEG  = 4'h0;

   typedef enum logic [1:0] {
      MSR_S_IDLE = 2'b00,
      MSR_S_READ = 2'b01,
      MSR_S_DONE = 2'b10
   } msr_state_t;

   typedef enum logic [2:0] {
      MSR_K_NONE  = 3'b000,
      MSR_K_SPR   = 3'b001,
      MSR_K_SR    = 3'b010,
      MSR_K_SRI   = 3'b011,
      MSR_K_SRIN  = 3'b100
   } msr_kind_t;

   // selector field holds the low half of the number first
   function automatic logic [9:0] msr_swap(input logic [9:0] sel);
      msr_swap = {sel[4:0], sel[9:5]};
   endfunction
endpackage

module msr_spr_dec
   import msr_pkg::*;
(
   input  wire logic [9:0] spr_num,
   input  wire logic       older_variant,
   output logic            spr_valid,
   output logic            spr_priv
);
   // returns {valid, privileged}
   function automatic logic [1:0] spr_class(input logic [9:0] n, input logic older);
      logic [1:0] r;
      r = 2'b00;
      case (n)
         MSR_N_FIXED_EXC, MSR_N_LINK, MSR_N_COUNT: begin
            r = 2'b10;
         end
         MSR_N_FAULT_CAUSE, MSR_N_FAULT_ADDR, MSR_N_PAGE_BASE, MSR_N_SAVE_PC,
         MSR_N_SAVE_STATE, MSR_N_EXT_ACCESS, MSR_N_TB_LOWER, MSR_N_TB_UPPER: begin
            r = 2'b11;
         end
         MSR_N_DEC_NEW: begin
            r = older ? 2'b00 : 2'b11;
         end
         MSR_N_MUL_QUOT, MSR_N_RTC_UPPER, MSR_N_RTC_LOWER, MSR_N_DEC_OLD: begin
            r = older ? 2'b10 : 2'b00;
         end
         default: begin
            if ((n >= MSR_N_SCRATCH_LO && n <= MSR_N_SCRATCH_HI) ||
                (n >= MSR_N_WINDOW_LO && n <= MSR_N_WINDOW_HI)) begin
               r = 2'b11;
            end else begin
               r = 2'b00;
            end
         end
      endcase
      spr_class = r;
   endfunction

   always_comb begin
      spr_valid = spr_class(spr_num, older_variant) > 2'b01;
      spr_priv  = spr_class(spr_num, older_variant) == 2'b11;
   end
endmodule

`default_nettype wire

/* File: msr_exec.sv */
// decode and execution of special and segment register reads into a gpr
//
// Behaviour
// - opcode 31/339, selector from bits 11-20
// - write selected special register to target
// - swap the two five-bit selector halves
// - numbers map to fixed, link, count, scratch, windows
// - 1, 8, 9 free; others supervisor only
// - unlisted selector is invalid, no read
// - special read leaves exception and cr0 alone
// - older variant: 0, 4, 5 free
// - decrementer 22 newer privileged, 6 older free
// - opcode 31/595 copies named segment register
// - direct segment read privileged only in newer
// - segment reads: exception untouched, cr0 undefined when record bit set
// - older indirect: sum selects segment register
// - sum written back unless source is 0 or same as target
// - sum-based indirect read older variant only
// - newer indirect: source bits 0-3 select
// - register-selected indirect read newer only
`timescale 1ns/1ps
`default_nettype none

module msr_exec
   import msr_pkg::*;
(
   input  wire logic        clk_sys,
   input  wire logic        rst_n,
   input  wire logic        instr_valid,
   input  wire logic [31:0] instr_word,
   input  wire logic        older_variant,
   input  wire logic        supervisor,
   input  wire logic [31:0] gpr_a_data,
   input  wire logic [31:0] gpr_b_data,
   input  wire logic [31:0] spr_rdata,
   input  wire logic [31:0] seg_rdata,
   output logic             instr_ready,
   output logic             spr_rd_en,
   output logic [9:0]       spr_rd_num,
   output logic             seg_rd_en,
   output logic [3:0]       seg_rd_idx,
   output logic             wb_valid,
   output logic [4:0]       wb_gpr,
   output logic [31:0]      wb_data,
   output logic             upd_valid,
   output logic [4:0]       upd_gpr,
   output logic [31:0]      upd_data,
   output logic             exc_valid,
   output logic [1:0]       exc_cause,
   output logic             cr0_undef
);

   msr_state_t  state_q;
   msr_kind_t   kind_d;
   msr_kind_t   kind_q;
   logic        ready_q;
   logic        spr_en_q;
   logic [9:0]  spr_num_q;
   logic        seg_en_q;
   logic [3:0]  seg_idx_q;
   logic        wb_valid_q;
   logic [4:0]  wb_gpr_q;
   logic [31:0] wb_data_q;
   logic        upd_pend_q;
   logic        upd_valid_q;
   logic [4:0]  upd_gpr_q;
   logic [31:0] upd_data_q;
   logic        exc_valid_q;
   logic [1:0]  exc_cause_q;
   logic        rec_q;
   logic        cr0_q;

   logic [5:0]  prim;
   logic [9:0]  xo;
   logic [4:0]  tgt_gpr_field;
   logic [4:0]  first_source_gpr_field;
   logic [9:0]  spr_num_d;
   logic        spr_valid;
   logic        spr_priv;
   logic [31:0] sum_d;
   logic [3:0]  seg_idx_d;
   logic        upd_d;
   logic [1:0]  cause_d;
   logic        take;

   default clocking msr_cb @(posedge clk_sys);
   endclocking
   default disable iff (!rst_n);

   always_comb begin
      prim                   = instr_word[MSR_F_PRIM_LSB +: 6];
      xo                     = instr_word[MSR_F_XO_LSB +: MSR_SPR_W];
      tgt_gpr_field          = instr_word[MSR_F_TGT_LSB +: MSR_GIDX_W];
      first_source_gpr_field = instr_word[MSR_F_A_LSB +: MSR_GIDX_W];
      spr_num_d              = msr_swap(instr_word[MSR_F_B_LSB +: MSR_SPR_W]);
   end

   msr_spr_dec u_spr_dec (
      .spr_num       (spr_num_d),
      .older_variant (older_variant),
      .spr_valid     (spr_valid),
      .spr_priv      (spr_priv)
   );

   // instruction class
   always_comb begin
      kind_d = MSR_K_NONE;
      if (prim == MSR_OP_PRIMARY) begin
         case (xo)
            MSR_XO_MFSPR:  kind_d = MSR_K_SPR;
            MSR_XO_MFSR:   kind_d = MSR_K_SR;
            MSR_XO_MFSRI:  kind_d = MSR_K_SRI;
            MSR_XO_MFSRIN: kind_d = MSR_K_SRIN;
            default:       kind_d = MSR_K_NONE;
         endcase
      end
   end

   // segment index, sum and fault
   always_comb begin
      sum_d     = gpr_a_data + gpr_b_data;
      seg_idx_d = MSR_RST_SEG;
      upd_d     = 1'b0;
      cause_d   = MSR_EXC_NONE;
      case (kind_d)
         MSR_K_SPR: begin
            if (!spr_valid) begin
               cause_d = MSR_EXC_INVALID;
            end else if (spr_priv && !supervisor) begin
               cause_d = MSR_EXC_PRIV;
            end
         end
         MSR_K_SR: begin
            seg_idx_d = {1'b0, instr_word[MSR_F_SEG_MSB:MSR_F_SEG_LSB]};
            if (!older_variant && !supervisor) begin
               cause_d = MSR_EXC_PRIV;
            end
         end
         MSR_K_SRI: begin
            if (first_source_gpr_field != MSR_RST_GIDX) begin
               seg_idx_d = sum_d[MSR_G_SEG_LSB +: MSR_SEG_W];
               upd_d     = first_source_gpr_field != tgt_gpr_field;
            end else begin
               seg_idx_d = gpr_b_data[MSR_G_SEG_LSB +: MSR_SEG_W];
            end
            if (!older_variant) begin
               cause_d = MSR_EXC_INVALID;
            end
         end
         MSR_K_SRIN: begin
            seg_idx_d = gpr_b_data[MSR_G_SEG_LSB +: MSR_SEG_W];
            if (older_variant) begin
               cause_d = MSR_EXC_INVALID;
            end else if (!supervisor) begin
               cause_d = MSR_EXC_PRIV;
            end
         end
         default: begin
            cause_d = MSR_EXC_NONE;
         end
      endcase
   end

   // instructions of other classes are left for other units
   assign take = instr_valid && ready_q && (kind_d != MSR_K_NONE);

   // sequencing
   always_ff @(posedge clk_sys) begin
      if (!rst_n) begin
         state_q <= MSR_S_IDLE;
         ready_q <= 1'b0;
      end else begin
         case (state_q)
            MSR_S_IDLE: begin
               ready_q <= 1'b1;
               if (take) begin
                  ready_q <= 1'b0;
                  state_q <= (cause_d != MSR_EXC_NONE) ? MSR_S_DONE : MSR_S_READ;
               end
            end
            MSR_S_READ: begin
               state_q <= MSR_S_DONE;
            end
            MSR_S_DONE: begin
               state_q <= MSR_S_IDLE;
               ready_q <= 1'b1;
            end
            default: begin
               state_q <= MSR_S_IDLE;
               ready_q <= 1'b0;
            end
         endcase
      end
   end

   // captured instruction fields
   always_ff @(posedge clk_sys) begin
      if (!rst_n) begin
         kind_q     <= MSR_K_NONE;
         wb_gpr_q   <= MSR_RST_GIDX;
         upd_gpr_q  <= MSR_RST_GIDX;
         upd_pend_q <= 1'b0;
         rec_q      <= 1'b0;
      end else if (take) begin
         kind_q     <= kind_d;
         wb_gpr_q   <= tgt_gpr_field;
         upd_gpr_q  <= first_source_gpr_field;
         upd_pend_q <= upd_d && (cause_d == MSR_EXC_NONE);
         rec_q      <= instr_word[MSR_F_REC_BIT];
      end
   end

   // read request to the register files, one cycle
   always_ff @(posedge clk_sys) begin
      if (!rst_n) begin
         spr_en_q  <= 1'b0;
         spr_num_q <= MSR_RST_NUM;
         seg_en_q  <= 1'b0;
         seg_idx_q <= MSR_RST_SEG;
      end else begin
         spr_en_q <= 1'b0;
         seg_en_q <= 1'b0;
         if (take && cause_d == MSR_EXC_NONE) begin
            spr_en_q  <= kind_d == MSR_K_SPR;
            seg_en_q  <= kind_d != MSR_K_SPR;
            spr_num_q <= spr_num_d;
            seg_idx_q <= seg_idx_d;
         end
      end
   end

   // target write and sum write-back
   always_ff @(posedge clk_sys) begin
      if (!rst_n) begin
         wb_valid_q  <= 1'b0;
         wb_data_q   <= MSR_RST_DATA;
         upd_valid_q <= 1'b0;
         upd_data_q  <= MSR_RST_DATA;
         cr0_q       <= 1'b0;
      end else begin
         wb_valid_q  <= 1'b0;
         upd_valid_q <= 1'b0;
         cr0_q       <= 1'b0;
         if (take) begin
            upd_data_q <= sum_d;
         end
         if (state_q == MSR_S_READ) begin
            wb_valid_q  <= 1'b1;
            wb_data_q   <= (kind_q == MSR_K_SPR) ? spr_rdata : seg_rdata;
            upd_valid_q <= upd_pend_q;
            // segment reads with the record bit set mark cr0 undefined
            cr0_q       <= (kind_q != MSR_K_SPR) && rec_q;
         end
      end
   end

   // program exception, write suppressed
   always_ff @(posedge clk_sys) begin
      if (!rst_n) begin
         exc_valid_q <= 1'b0;
         exc_cause_q <= MSR_EXC_NONE;
      end else begin
         exc_valid_q <= 1'b0;
         if (take && cause_d != MSR_EXC_NONE) begin
            exc_valid_q <= 1'b1;
            exc_cause_q <= cause_d;
         end
      end
   end

   assign instr_ready = ready_q;
   assign spr_rd_en   = spr_en_q;
   assign spr_rd_num  = spr_num_q;
   assign seg_rd_en   = seg_en_q;
   assign seg_rd_idx  = seg_idx_q;
   assign wb_valid    = wb_valid_q;
   assign wb_gpr      = wb_gpr_q;
   assign wb_data     = wb_data_q;
   assign upd_valid   = upd_valid_q;
   assign upd_gpr     = upd_gpr_q;
   assign upd_data    = upd_data_q;
   assign exc_valid   = exc_valid_q;
   assign exc_cause   = exc_cause_q;
   assign cr0_undef   = cr0_q;

   // checks
   spr_swap_a: assert property (
      (take && kind_d == MSR_K_SPR && cause_d == MSR_EXC_NONE) |=>
         spr_rd_en && spr_rd_num == msr_swap($past(instr_word[20:11])))
      else $error("special number not swapped");

   spr_write_a: assert property (
      spr_rd_en |=> wb_valid && wb_data == $past(spr_rdata) && !exc_valid)
      else $error("special read data not written");

   priv_block_a: assert property (
      (take && kind_d == MSR_K_SPR && spr_valid && spr_priv && !supervisor) |=>
         exc_valid && exc_cause == MSR_EXC_PRIV && !spr_rd_en)
      else $error("privileged read in user state not blocked");

   bad_sel_a: assert property (
      (take && kind_d == MSR_K_SPR && !spr_valid) |=>
         exc_valid && exc_cause == MSR_EXC_INVALID ##1 !wb_valid)
      else $error("invalid selector not rejected");

   old_free_a: assert property (
      (take && kind_d == MSR_K_SPR && older_variant &&
       (spr_num_d == MSR_N_MUL_QUOT || spr_num_d == MSR_N_RTC_LOWER)) |=>
         spr_rd_en ##1 wb_valid)
      else $error("older-variant free read refused");

   dec_map_a: assert property (
      (take && kind_d == MSR_K_SPR && spr_num_d == MSR_N_DEC_NEW) |=>
         ($past(older_variant) ? (exc_valid && exc_cause == MSR_EXC_INVALID) :
          (spr_rd_en == $past(supervisor) && exc_valid != $past(supervisor))))
      else $error("decrementer number mishandled");

   seg_priv_a: assert property (
      (take && kind_d == MSR_K_SR) |=>
         (exc_valid == (!$past(older_variant) && !$past(supervisor))))
      else $error("direct segment read privilege wrong");

   sum_back_a: assert property (
      (take && kind_d == MSR_K_SRI && older_variant &&
       first_source_gpr_field != 5'h00 && first_source_gpr_field != tgt_gpr_field) |=>
         seg_rd_en ##1 upd_valid && upd_data == $past(gpr_a_data + gpr_b_data, 2))
      else $error("indirect sum not written back");

   same_reg_a: assert property (
      (take && kind_d == MSR_K_SRI && first_source_gpr_field == tgt_gpr_field) |=>
         !upd_valid [*3])
      else $error("sum written onto target register");

   variant_gate_a: assert property (
      (take && ((kind_d == MSR_K_SRI && !older_variant) ||
                (kind_d == MSR_K_SRIN && older_variant))) |=>
         exc_cause == MSR_EXC_INVALID && !seg_rd_en)
      else $error("indirect read decoded in wrong variant");

   srin_idx_a: assert property (
      (take && kind_d == MSR_K_SRIN && cause_d == MSR_EXC_NONE) |=>
         seg_rd_en && seg_rd_idx == $past(gpr_b_data[31:28]))
      else $error("register-selected index wrong");

   no_wb_exc_a: assert property (
      exc_valid |-> !wb_valid && !upd_valid && !spr_rd_en && !seg_rd_en)
      else $error("write alongside exception");

   cr0_spr_a: assert property (
      (wb_valid && $past(kind_q) == MSR_K_SPR) |-> !cr0_undef)
      else $error("special read marked cr0");

   spr_read_c: cover property (take && kind_d == MSR_K_SPR ##1 spr_rd_en ##1 wb_valid);
   sri_read_c: cover property (take && kind_d == MSR_K_SRI ##2 upd_valid);
   priv_exc_c: cover property (exc_valid && exc_cause == MSR_EXC_PRIV);
   srin_read_c: cover property (take && kind_d == MSR_K_SRIN ##1 seg_rd_en);

endmodule

`default_nettype wire

/* File: msr_regfile_model.sv */
// far-side register files answering the block's read strobes
`timescale 1ns/1ps
`default_nettype none

module msr_regfile_model (
   input  wire logic        clk_sys,
   input  wire logic        spr_rd_en,
   input  wire logic [9:0]  spr_rd_num,
   input  wire logic        seg_rd_en,
   input  wire logic [3:0]  seg_rd_idx,
   output logic [31:0]      spr_rdata,
   output logic [31:0]      seg_rdata
);
   logic [31:0] junk_q;

   initial junk_q = 32'h3c3c_3c3c;

   // outside a strobe the data lines change every cycle, never the last value
   always @(posedge clk_sys) begin
      junk_q <= ~junk_q + 32'h0000_0001;
   end

   always_comb begin
      spr_rdata = spr_rd_en ? (32'h5a00_0000 | {22'h00_0000, spr_rd_num}) : junk_q;
      seg_rdata = seg_rd_en ? (32'hc0de_0000 | {28'h000_0000, seg_rd_idx}) : ~junk_q;
   end
endmodule

`default_nettype wire

/* File: move_from_special_reg_exec_bench.sv */
// self-checking bench for the special and segment register read block
`timescale 1ns/1ps
`default_nettype none

module move_from_special_reg_exec_bench;
   import msr_pkg::*;
   localparam logic [31:0] ZW = 32'h0000_0000;
   logic        clk_sys, rst_n, instr_valid, older_variant, supervisor;
   logic        instr_ready, spr_rd_en, seg_rd_en, wb_valid, upd_valid, exc_valid, cr0_undef;
   logic [31:0] instr_word, gpr_a_data, gpr_b_data, spr_rdata, seg_rdata, wb_data, upd_data;
   logic [9:0]  spr_rd_num, s_num;
   logic [3:0]  seg_rd_idx, s_idx;
   logic [4:0]  wb_gpr, upd_gpr, s_gpr, s_ugpr;
   logic [1:0]  exc_cause, s_cause;
   logic        s_exc, s_wb, s_upd, s_cr0, s_rdy;
   logic [31:0] s_data, s_udata;
   int          fail_count, tests_run;

   msr_exec dut_u (.clk_sys(clk_sys), .rst_n(rst_n), .instr_valid(instr_valid),
      .instr_word(instr_word), .older_variant(older_variant), .supervisor(supervisor),
      .gpr_a_data(gpr_a_data), .gpr_b_data(gpr_b_data), .spr_rdata(spr_rdata),
      .seg_rdata(seg_rdata), .instr_ready(instr_ready), .spr_rd_en(spr_rd_en),
      .spr_rd_num(spr_rd_num), .seg_rd_en(seg_rd_en), .seg_rd_idx(seg_rd_idx),
      .wb_valid(wb_valid), .wb_gpr(wb_gpr), .wb_data(wb_data), .upd_valid(upd_valid),
      .upd_gpr(upd_gpr), .upd_data(upd_data), .exc_valid(exc_valid),
      .exc_cause(exc_cause), .cr0_undef(cr0_undef));

   msr_regfile_model model_u (.clk_sys(clk_sys), .spr_rd_en(spr_rd_en),
      .spr_rd_num(spr_rd_num), .seg_rd_en(seg_rd_en), .seg_rd_idx(seg_rd_idx),
      .spr_rdata(spr_rdata), .seg_rdata(seg_rdata));

   initial begin
      clk_sys = 1'b0;
      forever #20 clk_sys = ~clk_sys;
   end

   function automatic logic [31:0] mk(input logic [9:0] xo, input logic [4:0] t,
                                      input logic [4:0] a, input logic [4:0] b,
                                      input logic rc);
      return {MSR_OP_PRIMARY, t, a, b, xo, rc};
   endfunction

   // selector carries the low half of the number in its first five bits
   function automatic logic [31:0] spr_w(input logic [9:0] n, input logic rc);
      return mk(MSR_XO_MFSPR, 5'h0d, n[4:0], n[9:5], rc);
   endfunction

   function automatic logic [31:0] sv(input logic [9:0] n);
      return 32'h5a00_0000 | {22'h00_0000, n};
   endfunction

   function automatic logic [31:0] gv(input logic [3:0] i);
      return 32'hc0de_0000 | {28'h000_0000, i};
   endfunction

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      tests_run++;
      if (got !== exp) begin
         fail_count++;
         $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   // code: 0 success, 1 privileged, 2 invalid, 3 ignored
   task automatic op(input logic [31:0] w, input logic sup, input logic [31:0] a,
                     input logic [31:0] b, input logic [1:0] code);
      int n;
      n = 0;
      while (instr_ready !== 1'b1 && n < 20) begin
         @(posedge clk_sys);
         #1;
         n++;
      end
      chk(n < 20, 1'b1);
      instr_word = w;
      supervisor = sup;
      gpr_a_data = a;
      gpr_b_data = b;
      instr_valid = 1'b1;
      {s_exc, s_wb, s_upd, s_cr0, s_rdy} = '0;
      {s_num, s_idx, s_cause, s_gpr, s_ugpr, s_data, s_udata} = 'x;
      repeat (3) begin
         @(posedge clk_sys);
         #1;
         instr_valid = 1'b0;
         if (exc_valid === 1'b1) begin
            s_exc = 1'b1;
            s_cause = exc_cause;
            s_rdy = instr_ready;
         end
         if (spr_rd_en === 1'b1) s_num = spr_rd_num;
         if (seg_rd_en === 1'b1) s_idx = seg_rd_idx;
         if (wb_valid === 1'b1) begin
            {s_wb, s_gpr, s_data, s_cr0} = {1'b1, wb_gpr, wb_data, cr0_undef};
            {s_upd, s_ugpr, s_udata} = {upd_valid, upd_gpr, upd_data};
         end
      end
      chk(s_exc, code == 2'h1 || code == 2'h2);
      chk(s_wb, code == 2'h0);
      if (s_exc) chk(s_cause, code);
      if (s_exc) chk(s_rdy, 1'b0);
      if (s_wb) chk(s_gpr, w[25:21]);
      chk(instr_ready, 1'b1);
   endtask

   task automatic t_spr_map();
      logic [9:0] nums [7] = '{10'h001, 10'h008, 10'h009, 10'h012, 10'h11c, 10'h210, 10'h21f};
      older_variant = 1'b0;
      for (int i = 0; i < 7; i++) begin
         op(spr_w(nums[i], 1'b1), 1'b0, ZW, ZW, (i < 3) ? 2'h0 : MSR_EXC_PRIV);
         if (i < 3) chk(s_cr0, 1'b0);
         op(spr_w(nums[i], 1'b0), 1'b1, ZW, ZW, 2'h0);
         chk(s_num, nums[i]);
         chk(s_data, sv(nums[i]));
      end
      $display("test spr_map done");
   endtask

   task automatic t_spr_bad();
      logic [9:0] nums [5] = '{10'h014, 10'h11e, 10'h20f, 10'h220, 10'h100};
      for (int i = 0; i < 5; i++) begin
         op(spr_w(nums[i], 1'b0), 1'b1, ZW, ZW, MSR_EXC_INVALID);
         op(spr_w(nums[i], 1'b0), 1'b0, ZW, ZW, MSR_EXC_INVALID);
      end
      $display("test spr_bad done");
   endtask

   task automatic t_variant();
      logic [9:0] nums [4] = '{10'h000, 10'h004, 10'h005, 10'h006};
      for (int i = 0; i < 4; i++) begin
         older_variant = 1'b1;
         op(spr_w(nums[i], 1'b0), 1'b0, ZW, ZW, 2'h0);
         chk(s_data, sv(nums[i]));
         older_variant = 1'b0;
         op(spr_w(nums[i], 1'b0), 1'b1, ZW, ZW, MSR_EXC_INVALID);
      end
      op(spr_w(10'h016, 1'b0), 1'b0, ZW, ZW, MSR_EXC_PRIV);
      op(spr_w(10'h016, 1'b0), 1'b1, ZW, ZW, 2'h0);
      older_variant = 1'b1;
      op(spr_w(10'h016, 1'b0), 1'b1, ZW, ZW, MSR_EXC_INVALID);
      $display("test variant done");
   endtask

   task automatic t_seg_direct();
      older_variant = 1'b0;
      op(mk(MSR_XO_MFSR, 5'h06, 5'h0e, 5'h00, 1'b1), 1'b0, ZW, ZW, MSR_EXC_PRIV);
      op(mk(MSR_XO_MFSR, 5'h06, 5'h0e, 5'h00, 1'b1), 1'b1, ZW, ZW, 2'h0);
      chk(s_idx, 4'h7);
      chk(s_data, gv(4'h7));
      chk(s_cr0, 1'b1);
      older_variant = 1'b1;
      op(mk(MSR_XO_MFSR, 5'h02, 5'h06, 5'h00, 1'b0), 1'b0, ZW, ZW, 2'h0);
      chk(s_idx, 4'h3);
      chk(s_cr0, 1'b0);
      $display("test seg_direct done");
   endtask

   task automatic t_seg_sum();
      older_variant = 1'b1;
      op(mk(MSR_XO_MFSRI, 5'h06, 5'h05, 5'h04, 1'b1), 1'b0, 32'h1000_0000, 32'h9000_3000,
         2'h0);
      chk(s_idx, 4'ha);
      chk(s_data, gv(4'ha));
      chk({s_upd, s_ugpr}, {1'b1, 5'h05});
      chk(s_udata, 32'ha000_3000);
      op(mk(MSR_XO_MFSRI, 5'h07, 5'h07, 5'h04, 1'b0), 1'b0, 32'hf000_0001, 32'h2000_0000,
         2'h0);
      chk({s_upd, s_idx}, {1'b0, 4'h1});
      op(mk(MSR_XO_MFSRI, 5'h06, 5'h00, 5'h04, 1'b0), 1'b0, 32'h3000_0000, 32'hb000_0000,
         2'h0);
      chk({s_upd, s_idx}, {1'b0, 4'hb});
      older_variant = 1'b0;
      op(mk(MSR_XO_MFSRI, 5'h06, 5'h05, 5'h04, 1'b0), 1'b1, ZW, ZW, MSR_EXC_INVALID);
      $display("test seg_sum done");
   endtask

   task automatic t_seg_reg();
      older_variant = 1'b0;
      op(mk(MSR_XO_MFSRIN, 5'h09, 5'h00, 5'h03, 1'b1), 1'b1, ZW, 32'h5123_4567, 2'h0);
      chk(s_idx, 4'h5);
      chk({s_data, s_upd, s_cr0}, {gv(4'h5), 1'b0, 1'b1});
      op(mk(MSR_XO_MFSRIN, 5'h09, 5'h00, 5'h03, 1'b0), 1'b0, ZW, ZW, MSR_EXC_PRIV);
      older_variant = 1'b1;
      op(mk(MSR_XO_MFSRIN, 5'h09, 5'h00, 5'h03, 1'b0), 1'b1, ZW, ZW, MSR_EXC_INVALID);
      op(mk(10'h053, 5'h09, 5'h00, 5'h00, 1'b0), 1'b1, ZW, ZW, 2'h3);
      op(spr_w(10'h001, 1'b0) ^ 32'h8000_0000, 1'b1, ZW, ZW, 2'h3);
      $display("test seg_reg done");
   endtask

   task automatic final_report();
      $display("checks %0d mismatches %0d", tests_run, fail_count);
      if (fail_count == 0 && tests_run > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask

   initial begin
      #400000;
      fail_count++;
      final_report();
   end

   initial begin
      {rst_n, instr_valid, older_variant, supervisor} = '0;
      {instr_word, gpr_a_data, gpr_b_data} = '0;
      fail_count = 0;
      tests_run = 0;
      repeat (5) @(posedge clk_sys);
      #1;
      rst_n = 1'b1;
      repeat (2) @(posedge clk_sys);
      #1;
      t_spr_map();
      t_spr_bad();
      t_variant();
      t_seg_direct();
      t_seg_sum();
      t_seg_reg();
      final_report();
   end
endmodule

`default_nettype wire
